// ---- hw/afm_matcher.sv ----
/*
 Field matcher for one access control entry: ARP header checks, ICMP
 type and code, TCP/UDP port filters and TCP flag filters, with a
 register port for configuration and hit statistics.
 Assumes frame fields are parsed upstream, synchronous to core_clk,
 and valid in the single cycle frm_valid is high.
*/
// Chosen here: the register offsets and the strobed register port.
// What this block does
// RULE_01: Length setting tests ARP hardware length 6 and protocol length 4.
// RULE_02: Hardware-space setting tests ARP hardware type equal to Ethernet 1.
// RULE_03: Protocol-space setting tests ARP protocol type equal to 0x800.
// RULE_04: Specific ICMP type mode needs frame type equal to configured byte.
// RULE_05: Specific ICMP code mode needs frame code equal to configured byte.
// RULE_06: Source port filter is any, specific or range.
// RULE_07: Specific source mode hits only on equal 16-bit source port.
// RULE_08: Range source mode hits only when source port lies in interval.
// RULE_09: Destination port filter is any, specific or range.
// RULE_10: Specific destination mode hits only on equal destination port.
// RULE_11: Range destination mode hits only when port lies in interval.
// RULE_12: FIN setting 0 excludes FIN-set frames, 1 requires it, any ignores.
// RULE_13: SYN setting 0 excludes SYN-set frames, 1 requires it, any ignores.
// RULE_14: PSH setting 0 excludes PSH-set frames, 1 requires it, any ignores.
// RULE_15: ACK setting 0 excludes ACK-set frames, 1 requires it, any ignores.
// RULE_16: URG setting 0 excludes URG-set frames, 1 requires it, any ignores.
// RULE_17: Hit is the AND of every criterion that is not don't-care.
`timescale 1ns/1ps
`default_nettype none

module afm_matcher #(
   parameter int PORT_W = 16
) (
   // Clock and reset
   input  wire logic                         core_clk,
   input  wire logic                         rstn,
   // Register port
   input  wire logic [afm_pkg::ADDR_W-1:0]   reg_addr,
   input  wire logic [afm_pkg::DATA_W-1:0]   reg_wdata,
   input  wire logic                         reg_wr,
   input  wire logic                         reg_rd,
   output logic      [afm_pkg::DATA_W-1:0]   reg_rdata,
   // Parsed frame
   input  wire logic                         frm_valid,
   input  wire logic                         frm_is_arp,
   input  wire logic                         frm_is_icmp,
   input  wire logic                         frm_is_tcp,
   input  wire logic                         frm_is_udp,
   input  wire logic [7:0]                   frm_hln,
   input  wire logic [7:0]                   frm_pln,
   input  wire logic [15:0]                  frm_hrd,
   input  wire logic [15:0]                  frm_pro,
   input  wire logic [7:0]                   frm_icmp_type,
   input  wire logic [7:0]                   frm_icmp_code,
   input  wire logic [PORT_W-1:0]            frm_src_port,
   input  wire logic [PORT_W-1:0]            frm_dst_port,
   input  wire logic [7:0]                   frm_tcp_flags,
   // Classification result
   output logic                              hit_valid,
   output logic                              hit
);

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   logic [afm_pkg::CTRL_W-1:0]  ctrl_reg,     ctrl_next;
   logic [15:0]                 icmp_reg,     icmp_next;
   logic [31:0]                 src_reg,      src_next;
   logic [31:0]                 dst_reg,      dst_next;
   logic [afm_pkg::CNT_W-1:0]   hit_cnt_reg,  hit_cnt_next;
   logic [afm_pkg::CNT_W-1:0]   frm_cnt_reg,  frm_cnt_next;
   logic [afm_pkg::DATA_W-1:0]  rdata_reg,    rdata_next;
   logic                        hvld_reg,     hvld_next;
   logic                        hit_reg,      hit_next;

   logic                        wr_ctrl;
   logic                        wr_icmp;
   logic                        wr_src;
   logic                        wr_dst;
   logic                        wr_status;

   assign wr_ctrl   = reg_wr && (reg_addr == afm_pkg::OFS_CTRL);
   assign wr_icmp   = reg_wr && (reg_addr == afm_pkg::OFS_ICMP);
   assign wr_src    = reg_wr && (reg_addr == afm_pkg::OFS_SRC_PORT);
   assign wr_dst    = reg_wr && (reg_addr == afm_pkg::OFS_DST_PORT);
   assign wr_status = reg_wr && (reg_addr == afm_pkg::OFS_STATUS);

   // ----------------------------------------------------------------
   // Decoded settings
   // ----------------------------------------------------------------
   afm_pkg::afm_tri_e           len_set;
   afm_pkg::afm_tri_e           hrd_set;
   afm_pkg::afm_tri_e           pro_set;
   logic                        icmp_type_spec;
   logic                        icmp_code_spec;
   logic [7:0]                  icmp_type_val;
   logic [7:0]                  icmp_code_val;

   assign len_set        = afm_pkg::afm_tri_e'(ctrl_reg[afm_pkg::POS_LEN +: 2]);
   assign hrd_set        = afm_pkg::afm_tri_e'(ctrl_reg[afm_pkg::POS_HRD +: 2]);
   assign pro_set        = afm_pkg::afm_tri_e'(ctrl_reg[afm_pkg::POS_PRO +: 2]);
   assign icmp_type_spec = ctrl_reg[afm_pkg::POS_ICMP_TYPE];
   assign icmp_code_spec = ctrl_reg[afm_pkg::POS_ICMP_CODE];
   assign icmp_type_val  = icmp_reg[7:0];
   assign icmp_code_val  = icmp_reg[afm_pkg::POS_ICMP_CVAL +: 8];

   // Three-way test; a non-don't-care setting needs the protocol present
   function automatic logic tri_ok(afm_pkg::afm_tri_e s, logic applies,
                                   logic cond);
      case (s)
         afm_pkg::TRI_CLEAR: tri_ok = applies && !cond;
         afm_pkg::TRI_SET:   tri_ok = applies && cond;
         default:            tri_ok = 1'b1;
      endcase
   endfunction

   // ----------------------------------------------------------------
   // ARP and ICMP criteria
   // ----------------------------------------------------------------
   logic len_ok;
   logic hrd_ok;
   logic pro_ok;
   logic itype_ok;
   logic icode_ok;

   assign len_ok   = tri_ok(len_set, frm_is_arp,                            // RULE_01
                            (frm_hln == afm_pkg::ARP_HLN_ETH) &&
                            (frm_pln == afm_pkg::ARP_PLN_IPV4));
   assign hrd_ok   = tri_ok(hrd_set, frm_is_arp,                            // RULE_02
                            frm_hrd == afm_pkg::ARP_HRD_ETH);
   assign pro_ok   = tri_ok(pro_set, frm_is_arp,                            // RULE_03
                            frm_pro == afm_pkg::ARP_PRO_IP);
   assign itype_ok = !icmp_type_spec ||
                     (frm_is_icmp && frm_icmp_type == icmp_type_val);      // RULE_04
   assign icode_ok = !icmp_code_spec ||
                     (frm_is_icmp && frm_icmp_code == icmp_code_val);      // RULE_05

   // ----------------------------------------------------------------
   // TCP flag criteria: FIN, SYN, PSH, ACK, URG in that order
   // ----------------------------------------------------------------
   logic [afm_pkg::NUM_FLAGS-1:0] flag_ok;

   for (genvar i = 0; i < afm_pkg::NUM_FLAGS; i++) begin : g_flag          // RULE_16
      assign flag_ok[i] = tri_ok(                                           // RULE_12
         afm_pkg::afm_tri_e'(ctrl_reg[afm_pkg::POS_FLAG0 + 2*i +: 2]),      // RULE_15
         frm_is_tcp, frm_tcp_flags[afm_pkg::TCP_BIT[i]]);                   // RULE_13
   end                                                                      // RULE_14

   // ----------------------------------------------------------------
   // Port filters
   // ----------------------------------------------------------------
   afm_port_if #(.W(PORT_W)) src_if ();
   afm_port_if #(.W(PORT_W)) dst_if ();

   assign src_if.mode  = afm_pkg::afm_port_mode_e'(ctrl_reg[afm_pkg::POS_SRC_MODE +: 2]);
   assign src_if.lo    = src_reg[PORT_W-1:0];                               // RULE_07
   assign src_if.hi    = src_reg[afm_pkg::POS_PORT_HI +: PORT_W];           // RULE_08
   assign src_if.port  = frm_src_port;
   assign src_if.is_l4 = frm_is_tcp || frm_is_udp;
   assign dst_if.mode  = afm_pkg::afm_port_mode_e'(ctrl_reg[afm_pkg::POS_DST_MODE +: 2]);
   assign dst_if.lo    = dst_reg[PORT_W-1:0];                               // RULE_10
   assign dst_if.hi    = dst_reg[afm_pkg::POS_PORT_HI +: PORT_W];           // RULE_11
   assign dst_if.port  = frm_dst_port;
   assign dst_if.is_l4 = frm_is_tcp || frm_is_udp;

   afm_port_filter u_src_filter (.pif(src_if));                             // RULE_06
   afm_port_filter u_dst_filter (.pif(dst_if));                             // RULE_09

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   logic match_all;

   assign match_all = len_ok && hrd_ok && pro_ok && itype_ok && icode_ok &&
                      src_if.ok && dst_if.ok && (&flag_ok);                 // RULE_17

   always_comb begin
      ctrl_next    = ctrl_reg;
      icmp_next    = icmp_reg;
      src_next     = src_reg;
      dst_next     = dst_reg;
      hit_cnt_next = hit_cnt_reg;
      frm_cnt_next = frm_cnt_reg;
      rdata_next   = '0;
      hvld_next    = frm_valid;
      hit_next     = frm_valid && match_all;
      if (wr_ctrl) begin
         ctrl_next = reg_wdata[afm_pkg::CTRL_W-1:0];
      end
      if (wr_icmp) begin
         icmp_next = reg_wdata[15:0];
      end
      if (wr_src) begin
         src_next = reg_wdata;
      end
      if (wr_dst) begin
         dst_next = reg_wdata;
      end
      // Clear first so a frame in the clearing cycle is still counted
      if (wr_status) begin
         hit_cnt_next = '0;
         frm_cnt_next = '0;
      end
      if (frm_valid) begin
         frm_cnt_next = frm_cnt_next + 1'b1;
      end
      if (hit_next) begin
         hit_cnt_next = hit_cnt_next + 1'b1;
      end
      if (reg_rd) begin
         case (reg_addr)
            afm_pkg::OFS_CTRL:     rdata_next = {{(afm_pkg::DATA_W-afm_pkg::CTRL_W){1'b0}},
                                                 ctrl_reg};
            afm_pkg::OFS_ICMP:     rdata_next = {16'h0000, icmp_reg};
            afm_pkg::OFS_SRC_PORT: rdata_next = src_reg;
            afm_pkg::OFS_DST_PORT: rdata_next = dst_reg;
            afm_pkg::OFS_STATUS:   rdata_next = {frm_cnt_reg, hit_cnt_reg};
            default:               rdata_next = '0;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // State registers
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_reg    <= afm_pkg::RST_CTRL;
         icmp_reg    <= afm_pkg::RST_ICMP;
         src_reg     <= afm_pkg::RST_PORT;
         dst_reg     <= afm_pkg::RST_PORT;
         hit_cnt_reg <= '0;
         frm_cnt_reg <= '0;
         rdata_reg   <= '0;
         hvld_reg    <= 1'b0;
         hit_reg     <= 1'b0;
      end else begin
         ctrl_reg    <= ctrl_next;
         icmp_reg    <= icmp_next;
         src_reg     <= src_next;
         dst_reg     <= dst_next;
         hit_cnt_reg <= hit_cnt_next;
         frm_cnt_reg <= frm_cnt_next;
         rdata_reg   <= rdata_next;
         hvld_reg    <= hvld_next;
         hit_reg     <= hit_next;
      end
   end

   assign reg_rdata = rdata_reg;
   assign hit_valid = hvld_reg;
   assign hit       = hit_reg;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   property p_len_clear;
      @(posedge core_clk) disable iff (!rstn)
      frm_valid && frm_is_arp && len_set == afm_pkg::TRI_CLEAR &&
      frm_hln == afm_pkg::ARP_HLN_ETH && frm_pln == afm_pkg::ARP_PLN_IPV4
      |=> hit_valid && !hit;
   endproperty
   a_len_clear: assert property (p_len_clear) else $error("length clear hit"); // RULE_01

   property p_hrd_set;
      @(posedge core_clk) disable iff (!rstn)
      frm_valid && hrd_set == afm_pkg::TRI_SET &&
      !(frm_is_arp && frm_hrd == afm_pkg::ARP_HRD_ETH) |=> !hit;
   endproperty
   a_hrd_set: assert property (p_hrd_set) else $error("hardware space miss"); // RULE_02

   property p_pro_set;
      @(posedge core_clk) disable iff (!rstn)
      frm_valid && pro_set == afm_pkg::TRI_SET &&
      frm_pro != afm_pkg::ARP_PRO_IP |=> !hit;
   endproperty
   a_pro_set: assert property (p_pro_set) else $error("protocol space miss"); // RULE_03

   property p_icmp_type;
      @(posedge core_clk) disable iff (!rstn)
      hit |-> !$past(icmp_type_spec) ||
              $past(frm_icmp_type) == $past(icmp_type_val);
   endproperty
   a_icmp_type: assert property (p_icmp_type) else $error("icmp type wrong"); // RULE_04

   property p_icmp_code;
      @(posedge core_clk) disable iff (!rstn)
      hit |-> !$past(icmp_code_spec) ||
              $past(frm_icmp_code) == $past(icmp_code_val);
   endproperty
   a_icmp_code: assert property (p_icmp_code) else $error("icmp code wrong"); // RULE_05

   property p_src_spec;
      @(posedge core_clk) disable iff (!rstn)
      hit && $past(src_if.mode) == afm_pkg::PORT_SPEC
      |-> $past(frm_src_port) == $past(src_reg[PORT_W-1:0]);
   endproperty
   a_src_spec: assert property (p_src_spec) else $error("source port wrong"); // RULE_07

   property p_dst_range;
      @(posedge core_clk) disable iff (!rstn)
      frm_valid && dst_if.mode == afm_pkg::PORT_RANGE &&
      (frm_dst_port < dst_if.lo || frm_dst_port > dst_if.hi) |=> !hit;
   endproperty
   a_dst_range: assert property (p_dst_range) else $error("dest range wrong"); // RULE_11

   property p_fin_clear;
      @(posedge core_clk) disable iff (!rstn)
      frm_valid && frm_tcp_flags[afm_pkg::TCP_BIT[0]] &&
      ctrl_reg[afm_pkg::POS_FLAG0 +: 2] == afm_pkg::TRI_CLEAR |=> !hit;
   endproperty
   a_fin_clear: assert property (p_fin_clear) else $error("fin clear hit"); // RULE_12

   property p_urg_set;
      @(posedge core_clk) disable iff (!rstn)
      frm_valid && !frm_tcp_flags[afm_pkg::TCP_BIT[4]] &&
      ctrl_reg[afm_pkg::POS_FLAG0 + 8 +: 2] == afm_pkg::TRI_SET |=> !hit;
   endproperty
   a_urg_set: assert property (p_urg_set) else $error("urg set hit"); // RULE_16

   property p_all_any;
      @(posedge core_clk) disable iff (!rstn)
      frm_valid && ctrl_reg == afm_pkg::RST_CTRL |=> hit_valid && hit;
   endproperty
   a_all_any: assert property (p_all_any) else $error("dont-care missed"); // RULE_17

   property p_hit_only_valid;
      @(posedge core_clk) disable iff (!rstn)
      hit |-> hit_valid && $past(frm_valid);
   endproperty
   a_hit_only_valid: assert property (p_hit_only_valid) else $error("stray hit"); // RULE_17

endmodule

`default_nettype wire

// ---- hw/afm_pkg.sv ----
/*
 Shared constants and types of the access control entry field matcher:
 register offsets, field positions, reset values and setting codes.
 Assumes nothing; compiled before every other file of the block.
*/
package afm_pkg;

   // ----------------------------------------------------------------
   // Register map (byte addresses, one 32-bit word each)
   // ----------------------------------------------------------------
   localparam int          ADDR_W          = 8;
   localparam int          DATA_W          = 32;
   localparam logic [7:0]  OFS_CTRL        = 8'h00;
   localparam logic [7:0]  OFS_ICMP        = 8'h04;
   localparam logic [7:0]  OFS_SRC_PORT    = 8'h08;
   localparam logic [7:0]  OFS_DST_PORT    = 8'h0c;
   localparam logic [7:0]  OFS_STATUS      = 8'h10;

   // ----------------------------------------------------------------
   // Control word layout
   // ----------------------------------------------------------------
   localparam int          POS_LEN         = 0;
   localparam int          POS_HRD         = 2;
   localparam int          POS_PRO         = 4;
   localparam int          POS_FLAG0       = 6;
   localparam int          POS_ICMP_TYPE   = 16;
   localparam int          POS_ICMP_CODE   = 17;
   localparam int          POS_SRC_MODE    = 18;
   localparam int          POS_DST_MODE    = 20;
   localparam int          CTRL_W          = 22;
   localparam int          POS_ICMP_CVAL   = 8;
   localparam int          POS_PORT_HI     = 16;
   localparam int          POS_HIT_CNT     = 0;
   localparam int          POS_FRM_CNT     = 16;
   localparam int          CNT_W           = 16;

   // ----------------------------------------------------------------
   // Reset values: every criterion don't-care
   // ----------------------------------------------------------------
   localparam logic [21:0] RST_CTRL        = 22'h00aaaa;
   localparam logic [15:0] RST_ICMP        = 16'h0000;
   localparam logic [31:0] RST_PORT        = 32'h0000_0000;

   // ----------------------------------------------------------------
   // Protocol constants
   // ----------------------------------------------------------------
   localparam logic [7:0]  ARP_HLN_ETH     = 8'h06;
   localparam logic [7:0]  ARP_PLN_IPV4    = 8'h04;
   localparam logic [15:0] ARP_HRD_ETH     = 16'h0001;
   localparam logic [15:0] ARP_PRO_IP      = 16'h0800;
   localparam int          NUM_FLAGS       = 5;
   // TCP flag byte positions for FIN, SYN, PSH, ACK, URG
   localparam int          TCP_BIT [NUM_FLAGS] = '{0, 1, 3, 4, 5};

   // ----------------------------------------------------------------
   // Setting codes
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      TRI_CLEAR = 2'b00,
      TRI_SET   = 2'b01,
      TRI_ANY   = 2'b10,
      TRI_RSVD  = 2'b11
   } afm_tri_e;

   typedef enum logic [1:0] {
      PORT_ANY   = 2'b00,
      PORT_SPEC  = 2'b01,
      PORT_RANGE = 2'b10,
      PORT_RSVD  = 2'b11
   } afm_port_mode_e;

endpackage

// ---- hw/afm_port_filter.sv ----
/*
 One TCP/UDP port filter: any, specific value or inclusive range.
 Assumes a frame that is neither TCP nor UDP never passes a
 filter that is not don't-care.
*/
`timescale 1ns/1ps
`default_nettype none

module afm_port_filter (
   // Configuration and frame port
   afm_port_if.flt pif
);

   always_comb begin
      case (pif.mode)
         afm_pkg::PORT_ANY:   pif.ok = 1'b1;
         afm_pkg::PORT_SPEC:  pif.ok = pif.is_l4 && (pif.port == pif.lo);
         // Empty interval (lo above hi) never hits
         afm_pkg::PORT_RANGE: pif.ok = pif.is_l4 && (pif.port >= pif.lo) &&
                                       (pif.port <= pif.hi);
         default:             pif.ok = 1'b1;
      endcase
   end

endmodule

`default_nettype wire

// ---- hw/afm_port_if.sv ----
/*
 Carrier between the matcher top and its port filters.
 Assumes the top drives the configuration and frame port, the filter
 answers with ok in the same cycle.
*/
`timescale 1ns/1ps
`default_nettype none

interface afm_port_if #(parameter int W = 16);
   afm_pkg::afm_port_mode_e mode;
   logic [W-1:0]            lo;
   logic [W-1:0]            hi;
   logic [W-1:0]            port;
   logic                    is_l4;
   logic                    ok;

   modport ctl (output mode, lo, hi, port, is_l4, input ok);
   modport flt (input mode, lo, hi, port, is_l4, output ok);
endinterface

`default_nettype wire

// ---- tb/afm_frame_src.sv ----
/*
 Frame source standing in for the switch datapath.
 Assumes the bench calls send just after a rising edge of core_clk.
*/
`timescale 1ns/1ps
`default_nettype none

module afm_frame_src (
   // Clock
   input  wire logic         core_clk,
   // Parsed frame, class bits on top
   output logic             frm_valid,
   output logic [107:0]     frm_bus
);

   initial begin
      frm_valid = 1'b0;
      frm_bus   = '0;
   end

   // Idle fields carry the inverse so stale values never match by luck
   task automatic send(input logic [107:0] f, input logic last);
      frm_valid <= 1'b1;
      frm_bus   <= f;
      @(posedge core_clk);
      if (last) begin
         frm_valid <= 1'b0;
         frm_bus   <= ~f;
      end
   endtask

endmodule

`default_nettype wire

// ---- tb/test_afm_matcher.sv ----
/*
 Self-checking bench of the field matcher: register reset values,
 random configurations, biased random frames and hit statistics.
 Assumes afm_pkg, afm_port_if and the design files are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module test_afm_matcher;

   typedef struct packed {
      logic        arp, icmp, tcp, udp;
      logic [7:0]  hln, pln;
      logic [15:0] hrd, pro;
      logic [7:0]  ity, ico;
      logic [15:0] sp, dp;
      logic [7:0]  flg;
   } afm_tb_frm_s;

   logic          core_clk, rstn, reg_wr, reg_rd, frm_valid, hit_valid, hit, rd_pend;
   logic [7:0]    reg_addr;
   logic [31:0]   reg_wdata, reg_rdata, sp_r, dp_r;
   logic [107:0]  frm_bus;
   logic [21:0]   ctrl;
   logic [15:0]   icmp_r;
   afm_tb_frm_s   fw;
   logic          hitq[$];
   logic [31:0]   rdq[$];
   int            bad_count, checked;

   assign fw = frm_bus;

   afm_matcher dut_u (
      .core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .frm_valid(frm_valid),
      .frm_is_arp(fw.arp), .frm_is_icmp(fw.icmp), .frm_is_tcp(fw.tcp),
      .frm_is_udp(fw.udp), .frm_hln(fw.hln), .frm_pln(fw.pln), .frm_hrd(fw.hrd),
      .frm_pro(fw.pro), .frm_icmp_type(fw.ity), .frm_icmp_code(fw.ico),
      .frm_src_port(fw.sp), .frm_dst_port(fw.dp), .frm_tcp_flags(fw.flg),
      .hit_valid(hit_valid), .hit(hit));

   afm_frame_src src_u (.core_clk(core_clk), .frm_valid(frm_valid), .frm_bus(frm_bus));

   // ----------------------------------------------------------------
   // Reference model
   // ----------------------------------------------------------------
   function automatic logic tri_ok(logic [1:0] c, logic cond, logic cls);
      return (c == 2'b00) ? (cls && !cond) : (c == 2'b01) ? (cls && cond) : 1'b1;
   endfunction

   function automatic logic port_ok(logic [1:0] m, logic [31:0] r, logic [15:0] p, logic cls);
      return (m == 2'b01) ? (cls && p == r[15:0]) :
             (m == 2'b10) ? (cls && p >= r[15:0] && p <= r[31:16]) : 1'b1;
   endfunction

   function automatic logic exp_hit(afm_tb_frm_s f);
      logic h;
      h = tri_ok(ctrl[1:0], f.hln == 8'h06 && f.pln == 8'h04, f.arp);
      h &= tri_ok(ctrl[3:2], f.hrd == 16'h0001, f.arp);
      h &= tri_ok(ctrl[5:4], f.pro == 16'h0800, f.arp);
      h &= !ctrl[16] || (f.icmp && f.ity == icmp_r[7:0]);
      h &= !ctrl[17] || (f.icmp && f.ico == icmp_r[15:8]);
      h &= port_ok(ctrl[19:18], sp_r, f.sp, f.tcp | f.udp);
      h &= port_ok(ctrl[21:20], dp_r, f.dp, f.tcp | f.udp);
      for (int i = 0; i < 5; i++)
         h &= tri_ok(ctrl[6+2*i +: 2], f.flg[afm_pkg::TCP_BIT[i]], f.tcp);
      return h;
   endfunction

   // Boundary-heavy pick: both bounds and their outer neighbours
   function automatic logic [15:0] pick(logic [31:0] r);
      case ($urandom % 5)
         0: return r[15:0];
         1: return r[31:16];
         2: return r[15:0] - 16'h0001;
         3: return r[31:16] + 16'h0001;
         default: return 16'($urandom);
      endcase
   endfunction

   // ----------------------------------------------------------------
   // Drivers and checks
   // ----------------------------------------------------------------
   task automatic check(string n, logic [31:0] e, logic [31:0] s);
      checked++;
      if (s !== e) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask

   // Strobes stay up across calls so back-to-back accesses need no gap
   task automatic acc(logic w, logic [7:0] a, logic [31:0] d);
      reg_wr    <= w;
      reg_rd    <= !w;
      reg_addr  <= a;
      reg_wdata <= d;
      if (!w)
         rdq.push_back(d);
      @(posedge core_clk);
   endtask

   task automatic idle();
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      @(posedge core_clk);
   endtask

   task automatic give_verdict();
      if (bad_count == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   always @(posedge core_clk) begin
      if (rd_pend)
         check("reg_rdata", rdq.pop_front(), reg_rdata);
      else if (rstn && reg_rdata !== 32'h0)
         check("reg_rdata idle", 32'h0, reg_rdata);
      rd_pend <= reg_rd;
      if (hit_valid === 1'b1)
         check("hit", hitq.size() ? {31'h0, hitq.pop_front()} : 32'hffff_ffff, {31'h0, hit});
      else if (rstn && hit !== 1'b0)
         check("hit idle", 32'h0, {31'h0, hit});
   end

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   initial begin
      #200us;
      bad_count++;
      give_verdict();
   end

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      afm_tb_frm_s    f;
      logic [127:0]   rnd;
      logic [15:0]    nf, nh;
      logic           h;
      rstn = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      rd_pend = 1'b0;
      bad_count = 0;
      checked = 0;
      void'($urandom(78748));
      repeat (2) @(posedge core_clk);
      rstn <= 1'b1;
      acc(1'b0, afm_pkg::OFS_CTRL, 32'h0000_aaaa);
      acc(1'b0, afm_pkg::OFS_ICMP, 32'h0);
      acc(1'b0, afm_pkg::OFS_SRC_PORT, 32'h0);
      acc(1'b0, afm_pkg::OFS_DST_PORT, 32'h0);
      acc(1'b0, afm_pkg::OFS_STATUS, 32'h0);
      acc(1'b1, 8'h14, 32'hffff_ffff);
      acc(1'b0, 8'h14, 32'h0);
      for (int r = 0; r < 40; r++) begin
         ctrl = 22'($urandom);
         // Mostly don't-care so that hits stay frequent
         for (int i = 0; i < 8; i++)
            if ($urandom % 4)
               ctrl[2*i +: 2] = 2'b10;
         ctrl[17:16] = ctrl[17:16] & 2'($urandom);
         // First round keeps every criterion don't-care: all frames must hit
         if (r == 0)
            ctrl = afm_pkg::RST_CTRL;
         icmp_r = 16'($urandom);
         sp_r = $urandom;
         sp_r[31:16] = sp_r[15:0] + {8'h0, sp_r[23:16]};
         dp_r = $urandom;
         dp_r[31:16] = dp_r[15:0] + {8'h0, dp_r[23:16]};
         acc(1'b1, afm_pkg::OFS_CTRL, {10'h0, ctrl});
         acc(1'b1, afm_pkg::OFS_ICMP, {16'h0, icmp_r});
         acc(1'b1, afm_pkg::OFS_SRC_PORT, sp_r);
         acc(1'b1, afm_pkg::OFS_DST_PORT, dp_r);
         acc(1'b1, afm_pkg::OFS_STATUS, 32'h0);
         acc(1'b0, afm_pkg::OFS_CTRL, {10'h0, ctrl});
         idle();
         nf = 16'h0;
         nh = 16'h0;
         for (int k = 0; k < 8; k++) begin
            rnd = {$urandom, $urandom, $urandom, $urandom};
            f = rnd[107:0];
            if ($urandom % 2)
               {f.hln, f.pln} = 16'h0604;
            if ($urandom % 2)
               f.hrd = 16'h0001;
            if ($urandom % 2)
               f.pro = 16'h0800;
            if ($urandom % 2)
               {f.ico, f.ity} = icmp_r;
            f.sp = pick(sp_r);
            f.dp = pick(dp_r);
            h = exp_hit(f);
            hitq.push_back(h);
            nf++;
            nh = nh + {15'h0, h};
            src_u.send(f, k == 7);
         end
         idle();
         acc(1'b0, afm_pkg::OFS_STATUS, {nf, nh});
      end
      idle();
      idle();
      check("pending results", 32'h0, 32'(hitq.size()));
      give_verdict();
   end

endmodule

`default_nettype wire
